// file: common/rxq_pkg.sv
// What this block does
// - Break mid-character queues damaged char, then all-zero break char if it persists.
// - Three holding entries behind the shift register; load first empty entry.
// - Parity, framing and break flags stored per entry; overrun not stored.
// - Char available whenever at least one entry is queued.
// - Buffer read returns oldest entry and removes it with its flags.
// - Queue full when three entries held; interrupt condition selectable.
// - Character mode reports the flags of the head entry.
// - Block mode ORs flags of each char reaching head since last clear.
// - Status read leaves the queue unchanged; only buffer read pops.
// - With queue full, a new char waits in the shift register.
// - Second char while held discards held one; overrun set at its start bit.
// - Flow control negates RTS on start bit with queue full; reasserts when free.
// - Queue stays readable while the receiver is disabled.
// - Receiver reset clears queue, RTS state, flags and requests; stops reception until re-enabled, except in local loop with transmitter enabled.
// - New channel mode takes effect immediately, even mid-character.
// - Auto echo resends each received bit on TxD; CPU transmit path blocked.
// - Auto echo keeps transmit status inactive; bits, stops and break echoed raw.
// - Local loop routes transmitter to receiver, ignores RxD, holds TxD at mark.
// - Local loop clocks receiver from transmitter clock; only transmitter enabled.
// - Remote loop resends received bits on TxD; CPU transmit path blocked.
// - Remote loop: no chars to CPU, error flags inactive, no parity check.
// - Unused upper bits of short characters read as zero.
// - TxD is mark in normal mode when transmitter disabled or idle, and always in local loop.
package rxq_pkg;

  localparam int QDEPTH = 3;
  localparam logic [1:0] QCNT_RST = 2'h0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ECHO = 2'b01,
    MODE_LOCAL = 2'b10,
    MODE_REMOTE = 2'b11
  } chan_mode_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } err_flags_t;

  // One character handed over by the character assembler
  typedef struct packed {
    logic done;
    logic start;
    logic [3:0] bits;
    rx_entry_t ent;
  } rx_char_t;

endpackage : rxq_pkg

// file: hdl/rx_queue.sv
`timescale 1ns/10ps
module rx_queue
  import rxq_pkg::*;
(
  input wire logic mclk_i, // 100 MHz clock
  input wire logic reset_i, // Sync reset, high
  input wire logic rx_reset_cmd_i, // Receiver reset pulse
  input wire logic rx_enable_i, // Receiver enabled
  input wire logic tx_enable_i, // Transmitter enabled
  input wire logic tx_idle_i, // Transmitter idle
  input wire chan_mode_t chan_mode_i, // Channel mode
  input wire logic error_reporting_mode_i, // 0 char, 1 block
  input wire logic clear_error_summary_cmd_i, // Clear block flags
  input wire logic irq_sel_full_i, // 1: irq on full
  input wire logic rx_rts_enable_i, // Receiver flow control
  input wire logic rxd_i, // Serial in pin
  input wire logic tx_serial_i, // Transmitter serial bit
  input wire logic rx_bit_clk_i, // Receiver bit clock
  input wire logic tx_bit_clk_i, // Transmitter bit clock
  input wire rx_char_t asm_i, // Assembler result
  input wire logic rbuf_read_i, // Receive buffer read
  input wire logic status_read_i, // Status read
  output logic asm_serial_o, // Serial into assembler
  output logic asm_clk_o, // Bit clock to assembler
  output logic asm_run_o, // Assembler may run
  output logic tx_path_open_o, // CPU transmit path open
  output logic txd_o, // Serial out pin
  output logic rts_n_o, // Request to send, low
  output logic rx_char_available_o, // Queue not empty
  output logic rx_queue_full_o, // Queue full
  output logic rx_irq_o, // Receive interrupt request
  output logic tx_can_accept_gate_o, // Transmit status allowed
  output rx_entry_t rbuf_o, // Head entry data
  output err_flags_t status_o // Status error flags
);

  typedef struct packed {
    logic rxd_s1;
    logic rxd_s2;
    rx_entry_t [QDEPTH-1:0] q;
    logic [1:0] cnt;
    rx_entry_t shift;
    logic held;
    err_flags_t acc;
    logic overrun;
    logic rts_neg;
    logic run;
    logic txd;
    logic head_new;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [7:0] mask_bits(input logic [7:0] d, input logic [3:0] n);
    logic [7:0] m;
    m = 8'hff >> (4'h8 - n);
    return d & m;
  endfunction : mask_bits

  // Echo and remote loop send the line straight back out
  function automatic logic line_echoed(input chan_mode_t m);
    return (m == MODE_ECHO) || (m == MODE_REMOTE);
  endfunction : line_echoed

  function automatic logic is_local(input chan_mode_t m);
    return (m == MODE_LOCAL);
  endfunction : is_local

  function automatic logic q_full(input logic [1:0] n);
    return (n == 2'(QDEPTH));
  endfunction : q_full

  // Sticky OR of a head entry's flags into the summary
  function automatic err_flags_t merge_flags(input err_flags_t a, input rx_entry_t e);
    err_flags_t r;
    r = a;
    r.parity = a.parity | e.parity;
    r.framing = a.framing | e.framing;
    r.brk = a.brk | e.brk;
    return r;
  endfunction : merge_flags

  // Error flags as the status port shows them
  function automatic err_flags_t shown_flags(input logic blk, input logic avail,
      input err_flags_t acc, input rx_entry_t e);
    err_flags_t r;
    r = '0;
    if (blk) begin
      r.parity = acc.parity;
      r.framing = acc.framing;
      r.brk = acc.brk;
    end else begin
      r.parity = avail & e.parity;
      r.framing = avail & e.framing;
      r.brk = avail & e.brk;
    end
    return r;
  endfunction : shown_flags

  logic rx_line;
  logic remote;
  logic pop;
  logic push;
  rx_entry_t incoming;
  rx_entry_t head;

  always_comb begin
    remote = (chan_mode_i == MODE_REMOTE);
    rx_line = is_local(chan_mode_i) ? tx_serial_i : s_q.rxd_s2;
    asm_serial_o = rx_line;
    asm_clk_o = is_local(chan_mode_i) ? tx_bit_clk_i : rx_bit_clk_i;
    asm_run_o = s_q.run || (is_local(chan_mode_i) && tx_enable_i);
    tx_path_open_o = !line_echoed(chan_mode_i);
    tx_can_accept_gate_o = (chan_mode_i != MODE_ECHO);
    head = s_q.q[0];
    pop = rbuf_read_i && (s_q.cnt != 2'h0);
    incoming = asm_i.ent;
    incoming.data = mask_bits(asm_i.ent.data, asm_i.bits);
    if (asm_i.ent.brk) begin
      incoming.data = 8'h00;
    end
    push = asm_i.done && asm_run_o && !remote;
  end

  always_comb begin
    logic [1:0] c;
    logic [1:0] free_cnt;
    c = s_q.cnt;
    free_cnt = 2'h0;
    s_d = s_q;
    s_d.rxd_s1 = rxd_i;
    s_d.rxd_s2 = s_q.rxd_s1;
    s_d.head_new = 1'b0;
    // Clear first so a flag raised in the same cycle survives
    if (clear_error_summary_cmd_i) begin
      s_d.acc = '0;
      s_d.overrun = 1'b0;
    end
    if (rx_enable_i) begin
      s_d.run = 1'b1;
    end
    // Echo and remote loop follow the line bit by bit, otherwise transmitter or mark
    unique case (chan_mode_i)
      MODE_ECHO, MODE_REMOTE: s_d.txd = s_q.rxd_s2;
      MODE_LOCAL: s_d.txd = 1'b1;
      MODE_NORMAL: s_d.txd = (tx_enable_i && !tx_idle_i) ? tx_serial_i : 1'b1;
    endcase
    if (pop) begin
      s_d.q[0] = s_q.q[1];
      s_d.q[1] = s_q.q[2];
      s_d.q[2] = '0;
      c = c - 2'h1;
      s_d.head_new = (c != 2'h0);
    end
    // Held char moves in once an entry frees
    if (s_q.held && !q_full(c)) begin
      s_d.q[c] = s_q.shift;
      s_d.head_new = s_d.head_new || (c == 2'h0);
      c = c + 2'h1;
      s_d.held = 1'b0;
    end
    if (asm_i.start && asm_run_o && !remote) begin
      if (s_d.held && q_full(c)) begin
        s_d.overrun = 1'b1;
        s_d.held = 1'b0;
      end
      if (rx_rts_enable_i && q_full(c)) begin
        s_d.rts_neg = 1'b1;
      end
    end
    if (push) begin
      if (!q_full(c) && !s_d.held) begin
        s_d.q[c] = incoming;
        s_d.head_new = s_d.head_new || (c == 2'h0);
        c = c + 2'h1;
      end else begin
        s_d.shift = incoming;
        s_d.held = 1'b1;
      end
    end
    s_d.cnt = c;
    free_cnt = 2'(QDEPTH) - c;
    if (free_cnt != 2'h0 && !s_d.held) begin
      s_d.rts_neg = 1'b0;
    end
    // Accumulate head flags as each char reaches the head
    if (s_q.head_new) begin
      s_d.acc = merge_flags(s_d.acc, head);
    end
    if (rx_reset_cmd_i) begin
      s_d.q = '0;
      s_d.cnt = QCNT_RST;
      s_d.held = 1'b0;
      s_d.acc = '0;
      s_d.overrun = 1'b0;
      s_d.rts_neg = 1'b0;
      s_d.run = 1'b0;
      s_d.head_new = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.rxd_s1 <= 1'b1;
      s_q.rxd_s2 <= 1'b1;
      s_q.txd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    rx_char_available_o = (s_q.cnt != 2'h0);
    rx_queue_full_o = q_full(s_q.cnt);
    rx_irq_o = irq_sel_full_i ? rx_queue_full_o : rx_char_available_o;
    rbuf_o = head;
    status_o = shown_flags(error_reporting_mode_i, rx_char_available_o, s_q.acc, head);
    status_o.overrun = s_q.overrun;
    if (remote) begin
      status_o = '0;
    end
    txd_o = s_q.txd;
    rts_n_o = s_q.rts_neg;
  end

endmodule : rx_queue

// file: verif/rxq_props.sv
`timescale 1ns/10ps
module rxq_props
  import rxq_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic rx_reset_cmd_i, // Rx reset
  input wire chan_mode_t chan_mode_i, // Mode
  input wire logic error_reporting_mode_i, // Error mode
  input wire logic irq_sel_full_i, // Irq select
  input wire logic tx_serial_i, // Tx bit
  input wire rx_char_t asm_i, // Assembler
  input wire logic rbuf_read_i, // Pop
  input wire logic status_read_i, // Status read
  input wire logic asm_serial_o, // Rx serial
  input wire logic tx_path_open_o, // Tx path
  input wire logic txd_o, // Line out
  input wire logic rts_n_o, // Rts
  input wire logic rx_char_available_o, // Available
  input wire logic rx_queue_full_o, // Full
  input wire logic rx_irq_o, // Irq
  input wire logic tx_can_accept_gate_o, // Gate
  input wire rx_entry_t rbuf_o, // Head
  input wire err_flags_t status_o // Status
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  irq_select_a: assert property (
    rx_irq_o == (irq_sel_full_i ? rx_queue_full_o : rx_char_available_o)) else $error("irq");
  local_mark_a: assert property ((chan_mode_i == MODE_LOCAL) [*2] |-> txd_o)
    else $error("txd not mark");
  local_src_a: assert property (
    chan_mode_i == MODE_LOCAL |-> asm_serial_o == tx_serial_i) else $error("loop src");
  path_block_a: assert property (
    chan_mode_i inside {MODE_ECHO, MODE_REMOTE} |-> !tx_path_open_o) else $error("tx path");
  echo_gate_a: assert property (chan_mode_i == MODE_ECHO |-> !tx_can_accept_gate_o)
    else $error("echo gate");
  status_keep_a: assert property (
    status_read_i && !rbuf_read_i && !asm_i.done && !rx_reset_cmd_i |=> $stable(rbuf_o))
    else $error("status read popped");
  rx_reset_clear_a: assert property (
    rx_reset_cmd_i |=> !rx_char_available_o && !rts_n_o && status_o == '0)
    else $error("rx reset");
  remote_hold_a: assert property (
    chan_mode_i == MODE_REMOTE && !rx_char_available_o |=> !rx_char_available_o)
    else $error("remote push");
  char_flags_a: assert property (
    !error_reporting_mode_i && rx_char_available_o && chan_mode_i != MODE_REMOTE
    |-> status_o[3:1] == rbuf_o[10:8]) else $error("head flags");
  cover property (rx_queue_full_o);
  cover property (rts_n_o);
  cover property (status_o.overrun);
endmodule : rxq_props
bind rx_queue rxq_props rxq_props_inst (.mclk_i(mclk_i), .reset_i(reset_i),
  .rx_reset_cmd_i(rx_reset_cmd_i), .chan_mode_i(chan_mode_i), .asm_i(asm_i),
  .error_reporting_mode_i(error_reporting_mode_i), .irq_sel_full_i(irq_sel_full_i),
  .tx_serial_i(tx_serial_i), .rbuf_read_i(rbuf_read_i), .status_read_i(status_read_i),
  .asm_serial_o(asm_serial_o), .tx_path_open_o(tx_path_open_o), .txd_o(txd_o),
  .rts_n_o(rts_n_o), .rx_char_available_o(rx_char_available_o), .rbuf_o(rbuf_o),
  .rx_queue_full_o(rx_queue_full_o), .rx_irq_o(rx_irq_o), .status_o(status_o),
  .tx_can_accept_gate_o(tx_can_accept_gate_o));

// file: verif/rxq_remote.sv
`timescale 1ns/10ps
module rxq_remote (
  input wire logic mclk_i, // Clock
  input wire logic rts_n_i, // Flow control in
  output logic rxd_o = 1'b1 // Line to block
);
  logic [7:0] pat_q = 8'h5a;
  always @(posedge mclk_i) begin
    // Sender idles at mark while held off
    rxd_o <= #1 rts_n_i ? 1'b1 : pat_q[0];
    pat_q <= #1 {pat_q[0] ^ pat_q[5], pat_q[7:1]};
  end
endmodule : rxq_remote

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import rxq_pkg::*;
  logic mclk_i = 0, rst = 1, rrst = 0, ren = 0, ten = 1, emode = 0, clr = 0, isel = 1;
  logic txs = 0, rck = 0, tck = 0, rd = 0, srd = 0, rxd, av, full, irq, rts_n;
  logic rts_en = 1, txd, aser, aclk, arun, tpo, gate;
  logic [2:0] rh = 3'h7;
  chan_mode_t mode = MODE_NORMAL;
  rx_char_t a = '0;
  rx_entry_t rb, h, q[$];
  err_flags_t st, acc;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  logic [31:0] rs = 32'h29;
  always #5 mclk_i = ~mclk_i;
  always #35 rck = ~rck;
  always #45 tck = ~tck;
  always @(posedge mclk_i) txs <= #1 rs[3];
  always @(posedge mclk_i) rh <= {rh[1:0], rxd};
  rx_queue rx_queue_inst (.mclk_i(mclk_i), .reset_i(rst), .rx_reset_cmd_i(rrst),
    .rx_enable_i(ren), .tx_enable_i(ten), .tx_idle_i(txs), .chan_mode_i(mode),
    .error_reporting_mode_i(emode), .clear_error_summary_cmd_i(clr), .irq_sel_full_i(isel),
    .rx_rts_enable_i(rts_en), .rxd_i(rxd), .tx_serial_i(txs), .rx_bit_clk_i(rck),
    .tx_bit_clk_i(tck), .asm_i(a), .rbuf_read_i(rd), .status_read_i(srd),
    .asm_serial_o(aser), .asm_clk_o(aclk), .asm_run_o(arun), .tx_path_open_o(tpo),
    .txd_o(txd), .rts_n_o(rts_n), .rx_char_available_o(av), .rx_queue_full_o(full),
    .rx_irq_o(irq), .tx_can_accept_gate_o(gate), .rbuf_o(rb), .status_o(st));
  rxq_remote rxq_remote_inst (.mclk_i(mclk_i), .rts_n_i(rts_n), .rxd_o(rxd));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(logic [10:0] got, logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic push(logic keep);
    rx_entry_t n;
    logic [3:0] nb;
    rs = xs(rs);
    n = rs[10:0];
    nb = 4'h5 + 4'(rs[12:11]);
    for (int b = 0; b < 8; b++) if (b >= nb) n.data[b] = 1'b0;
    if (n.brk) n.data = '0;
    tick();
    a.done = 1;
    a.bits = nb;
    a.ent = n;
    acc[3:1] |= n[10:8];
    if (keep) q.push_back(n);
    tick();
    a.done = 0;
  endtask : push
  task automatic pop();
    srd = 1;
    tick();
    srd = 0;
    rd = 1;
    tick();
    rd = 0;
  endtask : pop
  always @(posedge mclk_i) begin
    if (rd && av) begin
      h = q.pop_front();
      chk(rb, h);
      if (!emode) chk(st[3:1], h[10:8]);
    end
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    tick(4);
    rst = 0;
    ren = 1;
    for (int i = 0; i < 4; i++) push(i < 3);
    a.start = 1;
    tick();
    a.start = 0;
    tick();
    chk({full, irq, rts_n, st.overrun}, 4'hf);
    repeat (3) pop();
    tick(2);
    chk({av, irq, rts_n}, 3'h0);
    $display("fifo test done");
    emode = 1;
    clr = 1;
    acc = '0;
    tick();
    clr = 0;
    repeat (3) push(1);
    rts_en = 0;
    a.start = 1;
    tick();
    a.start = 0;
    tick();
    chk({full, rts_n, st.overrun}, 3'h4);
    rts_en = 1;
    push(1);
    repeat (4) pop();
    tick(2);
    chk(st, acc);
    clr = 1;
    tick();
    clr = 0;
    tick();
    chk(st, 4'h0);
    $display("block test done");
    emode = 0;
    mode = MODE_REMOTE;
    push(0);
    tick();
    chk(av, 1'b0);
    mode = MODE_NORMAL;
    push(1);
    ren = 0;
    pop();
    push(1);
    rrst = 1;
    tick();
    rrst = 0;
    q.delete();
    push(0);
    tick();
    chk(av, 1'b0);
    for (int m = 1; m < 4; m++) begin
      mode = chan_mode_t'(m);
      tick(4);
      repeat (8) begin
        tick();
        chk(txd, (m == 2) ? 1'b1 : rh[2]);
        chk(aser, (m == 2) ? txs : rh[1]);
        chk({aclk, arun}, (m == 2) ? {tck, 1'b1} : {rck, 1'b0});
        chk({tpo, gate}, {m == 2, m != 1});
      end
    end
    mode = MODE_NORMAL;
    ten = 0;
    tick(2);
    chk(txd, 1'b1);
    $display("mode test done");
    conclude();
  end
endmodule : testbench
